// ==== enhanced_timer_10bit_tb.sv ====
`timescale 1ns/100ps
module enhanced_timer_10bit_tb;
    import et10_pkg::*;
    logic          clk;
    logic          resetn;
    et10_bus_req_t bus_req;
    logic [7:0]    bus_rdata;
    logic          tbc_tick;
    logic          ext_pin;
    logic          cap_pin;
    logic          a_out;
    logic          a_oe_n;
    logic          b_out;
    logic          b_oe_n;
    logic          flag_a;
    logic          flag_b;
    logic          flag_p;
    logic          rd_pend;
    logic [7:0]    exp_q[$];
    int            failures;
    int            tests_run;
    int            n;
    int            t;
    logic [9:0]    cmp;

    et10_timer dut_u (.clk(clk), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .tbc_tick(tbc_tick), .external_clock_pin(ext_pin), .channel_a_pin_in(cap_pin),
        .channel_a_pin_out(a_out), .channel_a_pin_oe_n(a_oe_n), .channel_b_pin_out(b_out),
        .channel_b_pin_oe_n(b_oe_n), .flag_a(flag_a), .flag_b(flag_b), .flag_p(flag_p));
    et10_far_model far_u (.clk(clk), .ext_pin(ext_pin), .cap_pin(cap_pin));

    always #12.5 clk = ~clk;

    always @(posedge clk) tbc_tick <= ($urandom_range(0, 7) == 0);

    task automatic check(input logic [9:0] seen, input logic [9:0] want);
        tests_run++;
        if (seen !== want) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic conclude();
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // A gap cycle after each strobe keeps every signal to one assignment per step.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] want);
        exp_q.push_back(want);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        @(posedge clk);
    endtask

    // Restarts the timer with a clock choice and counts cycles and time-base ticks to flag P.
    task automatic time_p(input logic [7:0] c0v, output int cyc, output int tb_n);
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_STATUS, 8'h07);
        wr(OFS_CTRL0, c0v);
        cyc = 0;
        tb_n = 0;
        while (flag_p !== 1'b1 && cyc < 10000) begin
            @(negedge clk);
            cyc++;
            if (tbc_tick === 1'b1) begin
                tb_n++;
            end
        end
        @(posedge clk);
    endtask

    // Read data stands only in the cycle after the strobe.
    always @(posedge clk) rd_pend <= bus_req.rd;
    always @(negedge clk) begin
        if (rd_pend === 1'b1) begin
            check({2'b00, bus_rdata}, {2'b00, exp_q.pop_front()});
        end
    end

    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        conclude();
    end

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        bus_req = '0;
        failures = 0;
        tests_run = 0;
        void'($urandom(53186));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(OFS_CTRL0, CTRL_RST);
        rd(OFS_CTRL1, CTRL_RST);
        rd(OFS_CNT_HI, 8'h00);
        rd(4'ha, 8'h00);
        @(negedge clk);
        check({9'h0, b_oe_n}, 10'h0);
        check({9'h0, b_out}, 10'h0);
        @(posedge clk);
        cmp = 10'($urandom_range(40, 120));
        wr(OFS_CMPA_LO, cmp[7:0]);
        wr(OFS_CMPA_HI, {6'h00, cmp[9:8]});
        rd(OFS_CMPA_LO, cmp[7:0]);
        rd(OFS_CMPA_HI, {6'h00, cmp[9:8]});
        wr(OFS_CNT_LO, 8'h55);
        rd(OFS_CNT_LO, 8'h00);
        wr(OFS_CTRL1, 8'h32);
        rd(OFS_CTRL1, 8'h30);
        // Compare mode, toggle on A match, initial level low, system clock.
        wr(OFS_CTRL0, 8'h19);
        n = 0;
        while (a_out !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check(10'(n >= cmp && n <= cmp + 3), 10'h1);
        check({9'h0, a_oe_n}, 10'h0);
        @(posedge clk);
        wr(OFS_CTRL0, 8'h11);
        wr(OFS_CTRL0, 8'h19);
        @(posedge clk);
        @(negedge clk);
        check({9'h0, a_out}, 10'h0);
        @(posedge clk);
        // Mode is changed only while the timer is off.
        wr(OFS_CTRL0, 8'h11);
        @(negedge clk);
        check({9'h0, flag_a}, 10'h1);
        check({9'h0, flag_b}, 10'h1);
        @(posedge clk);
        wr(OFS_STATUS, 8'h07);
        @(negedge clk);
        check({9'h0, flag_p}, 10'h0);
        check({9'h0, flag_b}, 10'h0);
        @(posedge clk);
        wr(OFS_CTRL1, 8'h00);
        wr(OFS_CTRL0, 8'h19);
        n = 0;
        while (flag_p !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check(10'(n >= 126 && n <= 130), 10'h1);
        @(posedge clk);
        wr(OFS_STATUS, 8'h04);
        @(negedge clk);
        check({9'h0, flag_p}, 10'h0);
        @(posedge clk);
        // External pin clock with pause and the reserved code.
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_CTRL0, 8'h68);
        far_u.pulses(5);
        wr(OFS_CTRL0, 8'he8);
        far_u.pulses(3);
        wr(OFS_CTRL0, 8'h68);
        far_u.pulses(4);
        repeat (6) @(posedge clk);
        rd(OFS_CNT_LO, 8'h09);
        wr(OFS_CTRL0, 8'h58);
        far_u.pulses(3);
        repeat (6) @(posedge clk);
        rd(OFS_CNT_LO, 8'h09);
        wr(OFS_CTRL0, 8'h78);
        far_u.pulses(2);
        repeat (6) @(posedge clk);
        rd(OFS_CNT_LO, 8'h0b);
        // Capture of the count on a rising edge at the channel A pin.
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_CTRL1, 8'h40);
        wr(OFS_STATUS, 8'h07);
        wr(OFS_CTRL0, 8'h68);
        far_u.pulses(6);
        repeat (6) @(posedge clk);
        far_u.cap_edge();
        repeat (6) @(posedge clk);
        rd(OFS_CMPA_LO, 8'h06);
        @(negedge clk);
        check({9'h0, flag_a}, 10'h1);
        @(posedge clk);
        // Timer mode with an A match clearing the counter; channel A pin control stays off.
        cmp = 10'($urandom_range(20, 60));
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_CTRL1, 8'hc1);
        wr(OFS_CMPA_LO, cmp[7:0]);
        wr(OFS_CMPA_HI, 8'h00);
        wr(OFS_STATUS, 8'h07);
        wr(OFS_CTRL0, 8'h19);
        n = 0;
        while (flag_a !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check(10'(n >= cmp && n <= cmp + 3), 10'h1);
        check({9'h0, a_oe_n}, 10'h1);
        repeat (200) @(negedge clk);
        check({9'h0, flag_p}, 10'h0);
        @(posedge clk);
        rd(OFS_CNT_HI, 8'h00);
        // Compare mode raising the pin on an A match.
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_CTRL1, 8'h20);
        wr(OFS_CTRL0, 8'h19);
        n = 0;
        while (a_out !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check(10'(n >= cmp && n <= cmp + 3), 10'h1);
        @(posedge clk);
        // PWM mode forced levels, with and without inversion.
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_CTRL1, 8'h98);
        @(negedge clk);
        check({9'h0, a_out}, 10'h1);
        check({9'h0, a_oe_n}, 10'h0);
        @(posedge clk);
        wr(OFS_CTRL1, 8'h8c);
        @(negedge clk);
        check({9'h0, a_out}, 10'h1);
        @(posedge clk);
        wr(OFS_CTRL1, 8'h88);
        @(negedge clk);
        check({9'h0, a_out}, 10'h0);
        @(posedge clk);
        // Prescaled and time-base clocks timed by the period match; the phase is free.
        wr(OFS_CTRL1, 8'hc0);
        time_p(8'h09, n, t);
        check(10'(n >= 508 && n <= 514), 10'h1);
        time_p(8'h29, n, t);
        check(10'(n >= 2030 && n <= 2050), 10'h1);
        time_p(8'h39, n, t);
        check(10'(n >= 8125 && n <= 8195), 10'h1);
        time_p(8'h49, n, t);
        check(10'(t >= 128 && t <= 129), 10'h1);
        conclude();
    end
endmodule

// ==== et10_far_model.sv ====
`timescale 1ns/100ps
module et10_far_model (
    // Clock.
    input  wire logic clk,
    // Pins driven toward the timer.
    output logic      ext_pin,
    output logic      cap_pin
);
    initial begin
        ext_pin = 1'b0;
        cap_pin = 1'b0;
    end

    // Slow edges give the pin synchroniser time to see every level.
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            ext_pin <= 1'b1;
            repeat (4) @(posedge clk);
            ext_pin <= 1'b0;
        end
    endtask

    task automatic cap_edge();
        @(posedge clk);
        cap_pin <= ~cap_pin;
    endtask
endmodule

// ==== et10_pkg.sv ====
package et10_pkg;

    // Counter and register widths.
    localparam int CNT_W  = 10;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;

    // Register offsets.
    localparam logic [3:0] OFS_CTRL0  = 4'h0;
    localparam logic [3:0] OFS_CTRL1  = 4'h1;
    localparam logic [3:0] OFS_CTRL2  = 4'h2;
    localparam logic [3:0] OFS_CNT_LO = 4'h3;
    localparam logic [3:0] OFS_CNT_HI = 4'h4;
    localparam logic [3:0] OFS_CMPA_LO = 4'h5;
    localparam logic [3:0] OFS_CMPA_HI = 4'h6;
    localparam logic [3:0] OFS_CMPB_LO = 4'h7;
    localparam logic [3:0] OFS_CMPB_HI = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'h9;

    // Field positions of control register 0.
    localparam int C0_PAUSE_BIT = 7;
    localparam int C0_CKS_LSB   = 4;
    localparam int C0_ON_BIT    = 3;
    localparam int C0_RP_LSB    = 0;

    // Field positions of control registers 1 and 2 (same layout per channel).
    localparam int CX_MODE_LSB = 6;
    localparam int CX_FUNC_LSB = 4;
    localparam int CX_OC_BIT   = 3;
    localparam int CX_POL_BIT  = 2;
    localparam int C1_DIR_BIT  = 1;
    localparam int C1_CLR_BIT  = 0;
    localparam int C2_PWM_LSB  = 0;

    // Status register flag positions.
    localparam int ST_A_BIT = 0;
    localparam int ST_B_BIT = 1;
    localparam int ST_P_BIT = 2;

    // Values after reset.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [9:0] CMP_RST  = 10'h000;

    // Clock source codes.
    localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
    localparam logic [2:0] CKS_SYS      = 3'h1;
    localparam logic [2:0] CKS_H_DIV16  = 3'h2;
    localparam logic [2:0] CKS_H_DIV64  = 3'h3;
    localparam logic [2:0] CKS_TBC      = 3'h4;
    localparam logic [2:0] CKS_NONE     = 3'h5;
    localparam logic [2:0] CKS_EXT_RISE = 3'h6;
    localparam logic [2:0] CKS_EXT_FALL = 3'h7;

    // Divider ratios of the prescaler.
    localparam int DIV_A = 4;
    localparam int DIV_B = 16;
    localparam int DIV_C = 64;

    // Output function codes.
    localparam logic [1:0] FN_00 = 2'h0;
    localparam logic [1:0] FN_01 = 2'h1;
    localparam logic [1:0] FN_10 = 2'h2;
    localparam logic [1:0] FN_11 = 2'h3;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'h0,
        MODE_CAPTURE = 2'h1,
        MODE_PWM     = 2'h2,
        MODE_TIMER   = 2'h3
    } et10_mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } et10_bus_req_t;

endpackage

// ==== et10_prescaler.sv ====
`timescale 1ns/100ps
module et10_prescaler
    import et10_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic resetn,
    // Divided enables.
    output logic      en_div_a,
    output logic      en_div_b,
    output logic      en_div_c
);
    // The high speed clock is taken to be the system clock, so one counter serves all ratios.
    logic [5:0] pre;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre      <= 6'h00;
            en_div_a <= 1'b0;
            en_div_b <= 1'b0;
            en_div_c <= 1'b0;
        end else begin
            pre      <= pre + 6'h01;
            en_div_a <= (pre[1:0] == 2'(DIV_A - 1));
            en_div_b <= (pre[3:0] == 4'(DIV_B - 1));
            en_div_c <= (pre == 6'(DIV_C - 1));
        end
    end
endmodule

// ==== et10_sync_edge.sv ====
`timescale 1ns/100ps
module et10_sync_edge
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic resetn,
    // Pin and its edges.
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);
    logic s1;
    logic s2;
    logic s3;

    // Only s2 and s3 feed the edge detector; s1 may be metastable.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    assign rise = s2 & ~s3;
    assign fall = ~s2 & s3;
endmodule

// ==== et10_timer.sv ====
`timescale 1ns/100ps
module et10_timer
    import et10_pkg::*;
(
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          resetn,
    // Register port.
    input  wire et10_bus_req_t bus_req,
    output logic [7:0]         bus_rdata,
    // Clock sources.
    input  wire logic          tbc_tick,
    input  wire logic          external_clock_pin,
    // Channel A pin.
    input  wire logic          channel_a_pin_in,
    output logic               channel_a_pin_out,
    output logic               channel_a_pin_oe_n,
    // Channel B pin.
    output logic               channel_b_pin_out,
    output logic               channel_b_pin_oe_n,
    // Match request flags.
    output logic               flag_a,
    output logic               flag_b,
    output logic               flag_p
);
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [9:0] cnt;
    logic [9:0] compare_a_value;
    logic [9:0] compare_b_value;
    logic       dir;
    logic       on_q;
    logic       a_lvl;
    logic       b_lvl;
    logic       en_div_a;
    logic       en_div_b;
    logic       en_div_c;
    logic       ext_rise;
    logic       ext_fall;
    logic       cap_rise;
    logic       cap_fall;
    logic       tick;

    et10_prescaler u_pre (
        .clk      (clk),
        .resetn   (resetn),
        .en_div_a (en_div_a),
        .en_div_b (en_div_b),
        .en_div_c (en_div_c)
    );

    et10_sync_edge u_ext (
        .clk    (clk),
        .resetn (resetn),
        .pin    (external_clock_pin),
        .rise   (ext_rise),
        .fall   (ext_fall)
    );

    et10_sync_edge u_cap (
        .clk    (clk),
        .resetn (resetn),
        .pin    (channel_a_pin_in),
        .rise   (cap_rise),
        .fall   (cap_fall)
    );

    // Decoded fields.
    et10_mode_t mode;
    logic [2:0] cks;
    logic [2:0] rp;
    logic [1:0] fn_a;
    logic [1:0] fn_b;
    logic       clr_sel;
    logic       oc_a;
    logic       pol_a;
    logic       single;
    logic       center;
    logic       cmp_like;

    assign mode     = et10_mode_t'(c1[CX_MODE_LSB +: 2]);
    assign cks      = c0[C0_CKS_LSB +: 3];
    assign rp       = c0[C0_RP_LSB +: 3];
    assign fn_a     = c1[CX_FUNC_LSB +: 2];
    assign fn_b     = c2[CX_FUNC_LSB +: 2];
    assign clr_sel  = c1[C1_CLR_BIT];
    assign oc_a     = c1[CX_OC_BIT];
    assign pol_a    = c1[CX_POL_BIT];
    assign single   = (mode == MODE_PWM) && (fn_a == FN_11);
    assign center   = (mode == MODE_PWM) && (fn_a == FN_10) && (c2[C2_PWM_LSB +: 2] != 2'h0);
    assign cmp_like = (mode == MODE_COMPARE) || (mode == MODE_TIMER);

    always_comb begin
        case (cks)
            CKS_SYS_DIV4: tick = en_div_a;
            CKS_SYS:      tick = 1'b1;
            CKS_H_DIV16:  tick = en_div_b;
            CKS_H_DIV64:  tick = en_div_c;
            CKS_TBC:      tick = tbc_tick;
            CKS_EXT_RISE: tick = ext_rise;
            CKS_EXT_FALL: tick = ext_fall;
            default:      tick = 1'b0;
        endcase
    end

    // Comparators and events.
    logic [9:0] p_top;
    logic       on_rise;
    logic       run;
    logic       a_hit;
    logic       b_hit;
    logic       p_hit;
    logic       a_evt;
    logic       b_evt;
    logic       p_evt;
    logic       cap_evt;
    logic       clr_evt;

    // A zero period field wraps to the all-ones top, which is the overflow.
    assign p_top   = {rp, 7'h00} - 10'h001;
    assign on_rise = c0[C0_ON_BIT] & ~on_q;
    assign run     = c0[C0_ON_BIT] & ~c0[C0_PAUSE_BIT] & tick & ~on_rise;
    assign a_hit   = (cnt == compare_a_value);
    assign b_hit   = (cnt == compare_b_value);
    assign p_hit   = (cnt == p_top) && !dir;
    assign a_evt   = run & a_hit;
    assign b_evt   = run & b_hit;
    assign p_evt   = run & p_hit & ~single & ~(cmp_like & clr_sel);

    always_comb begin
        case (fn_a)
            FN_00:   cap_evt = cap_rise;
            FN_01:   cap_evt = cap_fall;
            FN_10:   cap_evt = cap_rise | cap_fall;
            default: cap_evt = 1'b0;
        endcase
        cap_evt = cap_evt & (mode == MODE_CAPTURE) & c0[C0_ON_BIT];
    end

    always_comb begin
        if (cmp_like && clr_sel) begin
            clr_evt = run & a_hit;
        end else if (single || center) begin
            clr_evt = 1'b0;
        end else begin
            clr_evt = run & p_hit;
        end
    end

    // Counter; software has no write path to it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= CMP_RST;
            dir <= 1'b0;
        end else if (on_rise) begin
            cnt <= CMP_RST;
            dir <= 1'b0;
        end else if (run) begin
            if (clr_evt) begin
                cnt <= CMP_RST;
            end else if (center && !dir && p_hit) begin
                dir <= 1'b1;
                cnt <= cnt - 10'h001;
            end else if (dir) begin
                if (cnt == 10'h001) begin
                    dir <= 1'b0;
                end
                cnt <= cnt - 10'h001;
            end else begin
                cnt <= cnt + 10'h001;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            on_q <= 1'b0;
        end else begin
            on_q <= c0[C0_ON_BIT];
        end
    end

    // Control register 0; a software write wins over the single pulse start and stop.
    logic wr_c0;
    assign wr_c0 = bus_req.wr && (bus_req.addr == OFS_CTRL0);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            c0 <= CTRL_RST;
        end else if (wr_c0) begin
            c0 <= bus_req.wdata;
        end else if (single && a_evt) begin
            c0[C0_ON_BIT] <= 1'b0;
        end else if (single && ext_rise) begin
            c0[C0_ON_BIT] <= 1'b1;
        end
    end

    // Control registers 1 and 2; the direction bit is stored here but reads back as the counter direction.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            c1 <= CTRL_RST;
            c2 <= CTRL_RST;
        end else if (bus_req.wr) begin
            if (bus_req.addr == OFS_CTRL1) begin
                c1 <= bus_req.wdata;
            end
            if (bus_req.addr == OFS_CTRL2) begin
                c2 <= bus_req.wdata;
            end
        end
    end

    // Compare values; a capture beats a software write in the same cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            compare_a_value <= CMP_RST;
            compare_b_value <= CMP_RST;
        end else begin
            if (cap_evt) begin
                compare_a_value <= cnt;
            end else if (bus_req.wr && bus_req.addr == OFS_CMPA_LO) begin
                compare_a_value[7:0] <= bus_req.wdata;
            end else if (bus_req.wr && bus_req.addr == OFS_CMPA_HI) begin
                compare_a_value[9:8] <= bus_req.wdata[1:0];
            end
            if (bus_req.wr && bus_req.addr == OFS_CMPB_LO) begin
                compare_b_value[7:0] <= bus_req.wdata;
            end else if (bus_req.wr && bus_req.addr == OFS_CMPB_HI) begin
                compare_b_value[9:8] <= bus_req.wdata[1:0];
            end
        end
    end

    // Request flags; a new event wins over a write-one-to-clear.
    logic [2:0] st_clr;
    assign st_clr = (bus_req.wr && bus_req.addr == OFS_STATUS) ? bus_req.wdata[2:0] : 3'h0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_a <= 1'b0;
            flag_b <= 1'b0;
            flag_p <= 1'b0;
        end else begin
            flag_a <= (a_evt | cap_evt) | (flag_a & ~st_clr[ST_A_BIT]);
            flag_b <= b_evt | (flag_b & ~st_clr[ST_B_BIT]);
            flag_p <= p_evt | (flag_p & ~st_clr[ST_P_BIT]);
        end
    end

    // Compare mode pin levels.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            a_lvl <= 1'b0;
            b_lvl <= 1'b0;
        end else if (on_rise) begin
            a_lvl <= oc_a;
            b_lvl <= c2[CX_OC_BIT];
        end else begin
            if (a_evt) begin
                case (fn_a)
                    FN_01:   a_lvl <= 1'b0;
                    FN_10:   a_lvl <= 1'b1;
                    FN_11:   a_lvl <= ~a_lvl;
                    default: a_lvl <= a_lvl;
                endcase
            end
            if (b_evt) begin
                case (fn_b)
                    FN_01:   b_lvl <= 1'b0;
                    FN_10:   b_lvl <= 1'b1;
                    FN_11:   b_lvl <= ~b_lvl;
                    default: b_lvl <= b_lvl;
                endcase
            end
        end
    end

    // Channel A pin level before polarity.
    logic a_raw;
    always_comb begin
        if (mode == MODE_COMPARE) begin
            a_raw = a_lvl;
        end else begin
            case (fn_a)
                FN_00:   a_raw = ~oc_a;
                FN_01:   a_raw = oc_a;
                FN_10:   a_raw = (cnt < compare_a_value) ? oc_a : ~oc_a;
                default: a_raw = c0[C0_ON_BIT] ? oc_a : ~oc_a;
            endcase
        end
    end

    // Pins are registered, so they follow the internal level by one cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channel_a_pin_out  <= 1'b0;
            channel_a_pin_oe_n <= 1'b1;
            channel_b_pin_out  <= 1'b0;
            channel_b_pin_oe_n <= 1'b1;
        end else begin
            channel_a_pin_out  <= a_raw ^ pol_a;
            channel_a_pin_oe_n <= !((mode == MODE_COMPARE) || (mode == MODE_PWM));
            channel_b_pin_out  <= b_lvl ^ c2[CX_POL_BIT];
            channel_b_pin_oe_n <= (et10_mode_t'(c2[CX_MODE_LSB +: 2]) != MODE_COMPARE);
        end
    end

    // Read port; data stand for exactly one cycle after the strobe.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_rdata <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                OFS_CTRL0:   bus_rdata <= c0;
                OFS_CTRL1:   bus_rdata <= {c1[7:2], dir, c1[0]};
                OFS_CTRL2:   bus_rdata <= c2;
                OFS_CNT_LO:  bus_rdata <= cnt[7:0];
                OFS_CNT_HI:  bus_rdata <= {6'h00, cnt[9:8]};
                OFS_CMPA_LO: bus_rdata <= compare_a_value[7:0];
                OFS_CMPA_HI: bus_rdata <= {6'h00, compare_a_value[9:8]};
                OFS_CMPB_LO: bus_rdata <= compare_b_value[7:0];
                OFS_CMPB_HI: bus_rdata <= {6'h00, compare_b_value[9:8]};
                OFS_STATUS:  bus_rdata <= {5'h00, flag_p, flag_b, flag_a};
                default:     bus_rdata <= 8'h00;
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_quiet;
        !on_rise && !wr_c0;
    endsequence

    sequence s_a_raise;
        (mode == MODE_COMPARE) && (fn_a == FN_10) && a_evt
        ##1 ((mode == MODE_COMPARE) and s_quiet);
    endsequence

    AST_PAUSE_HOLD: assert property (
        c0[C0_PAUSE_BIT] && on_q && c0[C0_ON_BIT] |=> $stable(cnt))
        else $error("Counter moved while paused.");

    AST_RESERVED_CLK: assert property (
        (cks == CKS_NONE) && on_q |=> $stable(cnt))
        else $error("Counter moved with no clock source.");

    AST_ON_CLEAR: assert property (
        on_rise |=> (cnt == 10'h000) && !dir)
        else $error("Counter not cleared on switch-on.");

    AST_OFF_HOLD: assert property (
        (!c0[C0_ON_BIT] && !on_q) [*2] |-> $stable(cnt))
        else $error("Counter moved while off.");

    AST_PERIOD_CLEAR: assert property (
        cmp_like && !clr_sel && run && p_hit |=> (cnt == 10'h000) && flag_p)
        else $error("Period match did not clear counter or raise flag.");

    AST_A_CLEAR: assert property (
        cmp_like && clr_sel && run && a_hit |=> (cnt == 10'h000) && flag_a && !$rose(flag_p))
        else $error("A match did not clear counter.");

    AST_CMP_RAISE: assert property (
        s_a_raise |=> channel_a_pin_out == !$past(pol_a))
        else $error("Compare raise did not drive the pin high.");

    AST_CAPTURE: assert property (
        cap_evt |=> (compare_a_value == $past(cnt)) && flag_a)
        else $error("Capture did not latch the count.");

    AST_DIR_READ: assert property (
        bus_req.rd && (bus_req.addr == OFS_CTRL1) |=> bus_rdata[C1_DIR_BIT] == $past(dir))
        else $error("Direction flag read back wrongly.");

    AST_INIT_LEVEL: assert property (
        on_rise ##1 ((mode == MODE_COMPARE) and s_quiet)
        |=> channel_a_pin_out == ($past(oc_a, 2) ^ $past(pol_a)))
        else $error("Pin not returned to initial level on switch-on.");
endmodule
